// File: src/bbm_pkg.sv
// Package for the buck/boost modulation control block
package bbm_pkg;

  // Chip operating modes as seen by the modulation control
  typedef enum logic [2:0] {
    BBM_MODE_INIT,
    BBM_MODE_NORMAL,
    BBM_MODE_STOP,
    BBM_MODE_SLEEP,
    BBM_MODE_RESTART,
    BBM_MODE_FAILSAFE
  } bbm_mode_type;

  // Buck modulation technique
  typedef enum logic [1:0] {
    BBM_MOD_OFF,
    BBM_MOD_PWM,
    BBM_MOD_PFM
  } bbm_mod_type;

  // Configuration bits written by software
  typedef struct packed {
    logic auto_pwm_enable;
    logic wake_pin_pwm_control;
    logic pwm_pfm_lag_select;
    logic boost_enable;
    logic [1:0] boost_voltage_select;
  } bbm_cfg_type;

  // Analog comparator results fed to the control
  typedef struct packed {
    logic buck_over_pfm_current;
    logic buck_above_reset_level;
    logic supply_below_boost_level;
  } bbm_sense_type;

  // Reset value of the configuration (automatic switch disabled)
  localparam logic CFG_AUTO_PWM_RESET = 1'b0;
  localparam logic CFG_WAKE_PWM_RESET = 1'b0;
  localparam logic CFG_LAG_SEL_RESET = 1'b0;
  localparam logic CFG_BOOST_EN_RESET = 1'b0;
  localparam logic [1:0] BOOST_VSEL_LOWEST = 2'h0;

  // Clock and timing
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int BUCK_FSW_KHZ = 450;
  localparam int LAG_LONG_US = 1000;
  localparam int LAG_SHORT_US = 100;
  localparam int LAG_LONG_CYCLES = LAG_LONG_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int LAG_SHORT_CYCLES =
    LAG_SHORT_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int LAG_CNT_W = 16;

  // Threshold of the automatic switch, for reference only (analog side)
  localparam int AUTO_PWM_SWITCH_FLAG_THRESH_MA = 110;

endpackage

// File: src/bbm_lag_timer.sv
// Lag timer counting the PWM-to-PFM transition time
`timescale 1ns/1ps
module bbm_lag_timer
  import bbm_pkg::*;
#(
  parameter logic [LAG_CNT_W-1:0] LONG_CYCLES = LAG_CNT_W'(LAG_LONG_CYCLES),
  parameter logic [LAG_CNT_W-1:0] SHORT_CYCLES = LAG_CNT_W'(LAG_SHORT_CYCLES)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic long_select,
  // Status
  output logic busy,
  output logic done
);

  logic [LAG_CNT_W-1:0] count;

  // Down counter, restarted on each start pulse
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        // Load one less so done lands exactly on the last cycle
        count <= (long_select ? LONG_CYCLES : SHORT_CYCLES) - 1'b1;
        busy <= 1'b1;
      end else if (abort) begin
        busy <= 1'b0;
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 1'b1;
        end
      end
    end
  end

endmodule // bbm_lag_timer

// File: src/bbm_mode_seq.sv
// Chip mode sequencer for the regulator control
`timescale 1ns/1ps
module bbm_mode_seq
  import bbm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Requests
  input wire logic cmd_valid,
  input wire bbm_mode_type cmd_mode,
  input wire logic wake_event,
  input wire logic restart_done,
  // State
  output bbm_mode_type mode,
  output logic stop_entry
);

  bbm_mode_type next_mode;

  // Next mode from command, wake and restart completion
  always_comb begin
    next_mode = mode;
    unique case (mode)
      BBM_MODE_SLEEP, BBM_MODE_FAILSAFE: begin
        if (wake_event) begin
          next_mode = BBM_MODE_RESTART;
        end
      end
      BBM_MODE_RESTART: begin
        if (restart_done) begin
          next_mode = BBM_MODE_NORMAL;
        end
      end
      BBM_MODE_INIT, BBM_MODE_NORMAL, BBM_MODE_STOP: begin
        if (cmd_valid && cmd_mode != BBM_MODE_RESTART) begin
          next_mode = cmd_mode;
        end
      end
    endcase
  end

  // Mode register and stop-command pulse
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mode <= BBM_MODE_INIT;
      stop_entry <= 1'b0;
    end else begin
      mode <= next_mode;
      // Every accepted Stop command counts, even when already in Stop
      stop_entry <= (next_mode == BBM_MODE_STOP) &&
        (mode != BBM_MODE_STOP || cmd_valid);
    end
  end

endmodule // bbm_mode_seq

// File: src/bbm_modulation_ctrl.sv
// Buck/boost modulation control top level
`timescale 1ns/1ps
module bbm_modulation_ctrl
  import bbm_pkg::*;
#(
  parameter logic [LAG_CNT_W-1:0] LONG_CYCLES = LAG_CNT_W'(LAG_LONG_CYCLES),
  parameter logic [LAG_CNT_W-1:0] SHORT_CYCLES = LAG_CNT_W'(LAG_SHORT_CYCLES)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Configuration writes (mirror of hardware_control_register)
  input wire logic cfg_write,
  input wire bbm_cfg_type cfg_data,
  // Mode commands (mode_control_register)
  input wire logic mode_cmd_valid,
  input wire bbm_mode_type mode_cmd,
  // Wake sources
  input wire logic wake_input_pin,
  input wire logic transceiver_wake,
  // Analog sense
  input wire bbm_sense_type sense,
  // Status clear (wake_status_register write-one)
  input wire logic flag_clear,
  // Converter controls
  output bbm_mode_type chip_mode,
  output bbm_mod_type buck_mod,
  output logic buck_enable,
  output logic buck_soft_start,
  output logic boost_run,
  output logic [1:0] boost_level,
  output logic boost_fixed_freq,
  output logic [15:0] buck_fsw_khz,
  // Status and pins
  output bbm_cfg_type cfg,
  output logic auto_pwm_switch_flag,
  output logic interrupt_output_n,
  output logic reset_output_n,
  output logic lag_busy,
  output logic auto_armed
);

  // Overview: the sequencer owns the chip mode, the lag timer owns the
  // settling time, and this level turns both into converter controls.
  // Buck modulation is a register fed by one combinational decode, so
  // the lag timer sees the change one cycle before it is applied.
  // That look-ahead lets the timer start on the same edge as the PFM
  // switch instead of one cycle late.
  // Priority inside Stop, highest first:
  //   new Stop command (forces PFM; restarts the lag if the buck leaves PWM, except in pin-controlled Stop),
  //   automatic current trigger (only once armed),
  //   wake pin level (only with automatic control off),
  //   plain PFM.
  // The current comparator may chatter around its threshold; the
  // latch below keeps one event per Stop entry, so the interrupt
  // fires once and the host sees one flag, not a burst.
  // Limitation: the latch only clears on a new Stop command or on
  // leaving Stop, so the host must lighten the load before resending.
  // Boost control follows the enable and supply comparator in Normal,
  // Stop and Restart only, though the buck already runs in Init; its level comes from
  // configuration, so a Stop round trip leaves it untouched.
  // The level field is guarded against change while the boost is
  // enabled; a refused write keeps the old level without a status.
  // Sleep and Fail-Safe drop both converters at once; the wake-up
  // path goes through Restart, which ramps the buck with soft start
  // until the reset comparator trips.
  // Reset output is registered from the buck enable and comparator,
  // so it releases one cycle after both agree.
  // Trade-off: that cycle of latency keeps the pin free of glitches
  // from a comparator edge landing mid-cycle.

  logic stop_entry;
  logic lag_start;
  logic lag_done;
  logic auto_latched;
  logic auto_event;
  logic in_stop;
  logic pin_mode;
  logic want_pwm;
  logic restart_done;
  logic int_pulse;
  bbm_mod_type next_mod;

  // Converter is "switching" in PWM-like fashion
  function automatic logic is_pwm(input bbm_mod_type m);
    return m == BBM_MOD_PWM;
  endfunction

  // Restart decode shared by soft start and restart completion
  function automatic logic is_restart(input bbm_mode_type m);
    return m == BBM_MODE_RESTART;
  endfunction

  // Mode sequencer
  // Either wake source is enough; the sequencer only looks at it in
  // Sleep and Fail-Safe, so the pin is free for PWM control in Stop
  bbm_mode_seq u_seq (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cmd_valid(mode_cmd_valid),
    .cmd_mode(mode_cmd),
    .wake_event(wake_input_pin | transceiver_wake),
    .restart_done(restart_done),
    .mode(chip_mode),
    .stop_entry(stop_entry)
  );

  // Stop decode shared by timer abort and triggers
  assign in_stop = (chip_mode == BBM_MODE_STOP);

  // Pin-controlled Stop: the only case that skips the lag, since the
  // driver of the pin is expected to give a clean defined level;
  // automatic control takes priority when both are set
  assign pin_mode = in_stop && cfg.wake_pin_pwm_control &&
    !cfg.auto_pwm_enable;

  // Configuration register; automatic switch off after reset
  // Every field but a refused boost level is taken on one strobe so that the controls never
  // mix an old and a new setting for a cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg.auto_pwm_enable <= CFG_AUTO_PWM_RESET;
      cfg.wake_pin_pwm_control <= CFG_WAKE_PWM_RESET;
      cfg.pwm_pfm_lag_select <= CFG_LAG_SEL_RESET;
      cfg.boost_enable <= CFG_BOOST_EN_RESET;
      cfg.boost_voltage_select <= BOOST_VSEL_LOWEST;
    end else if (cfg_write) begin
      cfg.auto_pwm_enable <= cfg_data.auto_pwm_enable;
      cfg.wake_pin_pwm_control <= cfg_data.wake_pin_pwm_control;
      cfg.pwm_pfm_lag_select <= cfg_data.pwm_pfm_lag_select;
      cfg.boost_enable <= cfg_data.boost_enable;
      // Boost level may only change while the boost is disabled
      if (!cfg.boost_enable) begin
        cfg.boost_voltage_select <= cfg_data.boost_voltage_select;
      end
    end
  end

  // Lag timer restarts whenever buck leaves PWM for PFM, except in pin-controlled Stop
  // Taken from the next value, so the count begins on the very edge
  // at which the modulation changes
  assign lag_start = is_pwm(buck_mod) && (next_mod == BBM_MOD_PFM) &&
    !pin_mode;

  // Leaving Stop aborts a running lag; a later entry starts afresh
  // with whatever length is configured at that moment
  bbm_lag_timer #(
    .LONG_CYCLES(LONG_CYCLES),
    .SHORT_CYCLES(SHORT_CYCLES)
  ) u_lag (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(lag_start),
    .abort(!in_stop),
    .long_select(cfg.pwm_pfm_lag_select),
    .busy(lag_busy),
    .done(lag_done)
  );

  // Detection armed only after the lag, cleared on leaving Stop
  // A restart of the lag disarms at once, so a trip seen while the
  // loop still settles is never taken as overcurrent
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      auto_armed <= 1'b0;
    end else if (!in_stop || lag_start) begin
      auto_armed <= 1'b0;
    end else if (lag_done) begin
      auto_armed <= 1'b1;
    end
  end

  // Automatic trigger: enabled, armed, current above threshold
  // One-cycle event; the latch masks it until the next Stop entry
  assign auto_event = in_stop && cfg.auto_pwm_enable && auto_armed &&
    !auto_latched && sense.buck_over_pfm_current;

  // Latched PWM after automatic switch until a new Stop command
  // The Stop command wins over a trip in the same cycle: the host
  // asked for PFM, though from PFM the lag does not restart and the trigger stays armed
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      auto_latched <= 1'b0;
    end else if (!in_stop || stop_entry) begin
      auto_latched <= 1'b0;
    end else if (auto_event) begin
      auto_latched <= 1'b1;
    end
  end

  // Requested PWM in Stop; automatic has priority over the pin
  // The event term lets PWM start on the trip edge itself rather
  // than one cycle later from the latch
  always_comb begin
    want_pwm = 1'b0;
    if (cfg.auto_pwm_enable) begin
      want_pwm = auto_latched || auto_event;
    end else if (cfg.wake_pin_pwm_control) begin
      want_pwm = wake_input_pin;
    end
  end

  // Next modulation by chip mode
  // Init already runs the buck in PWM so the supply comes up first
  always_comb begin
    next_mod = BBM_MOD_OFF;
    unique case (chip_mode)
      BBM_MODE_NORMAL, BBM_MODE_RESTART, BBM_MODE_INIT: begin
        next_mod = BBM_MOD_PWM;
      end
      BBM_MODE_STOP: begin
        if (stop_entry) begin
          next_mod = BBM_MOD_PFM;
        end else begin
          next_mod = want_pwm ? BBM_MOD_PWM : BBM_MOD_PFM;
        end
      end
      BBM_MODE_SLEEP, BBM_MODE_FAILSAFE: begin
        next_mod = BBM_MOD_OFF;
      end
    endcase
  end

  // Modulation register; off until the first edge after reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      buck_mod <= BBM_MOD_OFF;
    end else begin
      buck_mod <= next_mod;
    end
  end

  // Buck enable, soft start and switching frequency
  // Enable and frequency come from the next modulation so they change on the
  // same edge as the modulation register; soft start comes from the mode and reset comparator
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      buck_enable <= 1'b0;
      buck_soft_start <= 1'b0;
      buck_fsw_khz <= 16'h0;
    end else begin
      buck_enable <= (next_mod != BBM_MOD_OFF);
      // Ramp-up lasts until the output passes the reset level
      buck_soft_start <= is_restart(chip_mode) &&
        !sense.buck_above_reset_level;
      buck_fsw_khz <= is_pwm(next_mod) ? 16'(BUCK_FSW_KHZ) : 16'h0;
    end
  end

  // Boost: Normal, Stop, Restart only; config kept across modes
  // Init keeps the boost off: no configuration has been written yet
  // Fixed frequency follows the enable alone, so the modulation is
  // already set before the supply comparator first asks for boost
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      boost_run <= 1'b0;
      boost_level <= BOOST_VSEL_LOWEST;
      boost_fixed_freq <= 1'b0;
    end else begin
      boost_level <= cfg.boost_voltage_select;
      unique case (chip_mode)
        BBM_MODE_NORMAL, BBM_MODE_STOP, BBM_MODE_RESTART: begin
          // Runs while supply is below the selected level
          boost_run <= cfg.boost_enable &&
            sense.supply_below_boost_level;
          boost_fixed_freq <= cfg.boost_enable;
        end
        default: begin
          boost_run <= 1'b0;
          boost_fixed_freq <= 1'b0;
        end
      endcase
    end
  end

  // Restart ends when the buck output passes the reset threshold
  // Completion is a level, so a slow ramp simply stays in Restart
  assign restart_done = is_restart(chip_mode) &&
    sense.buck_above_reset_level;

  // Reset output: low while buck is below threshold
  // Gated by the enable so a stale comparator level in Sleep cannot
  // release the pin while the buck is off
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reset_output_n <= 1'b0;
    end else begin
      reset_output_n <= buck_enable && sense.buck_above_reset_level;
    end
  end

  // Sticky flag; a new event wins over a clear in the same cycle
  // Losing an event to a clear would hide a switch from the host,
  // so the set side has priority
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      auto_pwm_switch_flag <= 1'b0;
    end else if (auto_event) begin
      auto_pwm_switch_flag <= 1'b1;
    end else if (flag_clear) begin
      auto_pwm_switch_flag <= 1'b0;
    end
  end

  // Interrupt event: one-cycle low pulse per automatic switch
  // Registered so the pin never shows the combinational trigger
  // decode directly
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      int_pulse <= 1'b0;
    end else begin
      int_pulse <= auto_event;
    end
  end

  assign interrupt_output_n = ~int_pulse; // Active low pin

endmodule // bbm_modulation_ctrl

// File: tb/bbm_host_model.sv
// Host model issuing config writes and mode commands
`timescale 1ns/1ps
module bbm_host_model
  import bbm_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Requests
  output logic cfg_write,
  output bbm_cfg_type cfg_data,
  output logic mode_cmd_valid,
  output bbm_mode_type mode_cmd
);
  // Idle bus from time zero
  initial begin
    cfg_write = 0;
    cfg_data = '0;
    mode_cmd_valid = 0;
    mode_cmd = BBM_MODE_INIT;
  end
  // Config set before Stop so the auto switch takes effect
  task automatic set_cfg(input bbm_cfg_type c);
    @(posedge ref_clk);
    #1 cfg_write = 1;
    cfg_data = c;
    @(posedge ref_clk);
    #1 cfg_write = 0;
  endtask
  // Stop resent only once the load is light again
  task automatic send_mode(input bbm_mode_type m);
    @(posedge ref_clk);
    #1 mode_cmd_valid = 1;
    mode_cmd = m;
    @(posedge ref_clk);
    #1 mode_cmd_valid = 0;
  endtask
endmodule // bbm_host_model

// File: tb/bbm_modulation_ctrl_properties.sv
// Port assertions for the modulation control
`timescale 1ns/1ps
module bbm_modulation_ctrl_properties
  import bbm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Watched ports
  input wire logic wake_input_pin,
  input wire bbm_sense_type sense,
  input wire bbm_mode_type chip_mode,
  input wire bbm_mod_type buck_mod,
  input wire logic buck_enable,
  input wire logic boost_run,
  input wire logic boost_fixed_freq,
  input wire logic [15:0] buck_fsw_khz,
  input wire bbm_cfg_type cfg,
  input wire logic auto_pwm_switch_flag,
  input wire logic interrupt_output_n,
  input wire logic reset_output_n,
  input wire logic lag_busy,
  input wire logic auto_armed
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  property p_boost_pwm;
    boost_run |-> boost_fixed_freq;
  endproperty
  a_boost_pwm: assert property (p_boost_pwm)
    else $error("boost runs without fixed frequency");
  property p_fsw;
    buck_mod == BBM_MOD_PWM |-> buck_fsw_khz == 16'h01c2;
  endproperty
  a_fsw: assert property (p_fsw)
    else $error("pwm frequency wrong");
  property p_off;
    (chip_mode inside {BBM_MODE_SLEEP, BBM_MODE_FAILSAFE}) &&
      $past(chip_mode) == chip_mode |-> !buck_enable && !boost_run;
  endproperty
  a_off: assert property (p_off)
    else $error("converter on in low power mode");
  property p_irq;
    $fell(interrupt_output_n) |-> auto_pwm_switch_flag &&
      buck_mod == BBM_MOD_PWM ##1 interrupt_output_n;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt pulse wrong");
  property p_arm;
    lag_busy |-> !auto_armed;
  endproperty
  a_arm: assert property (p_arm)
    else $error("armed during lag");
  property p_rst;
    reset_output_n |-> $past(buck_enable) &&
      $past(sense.buck_above_reset_level);
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset released early");
  property p_pin;
    chip_mode == BBM_MODE_STOP && $past(chip_mode) == BBM_MODE_STOP &&
      $stable(cfg) && cfg.wake_pin_pwm_control && !cfg.auto_pwm_enable
      |-> buck_mod == ($past(wake_input_pin) ? BBM_MOD_PWM : BBM_MOD_PFM);
  endproperty
  a_pin: assert property (p_pin)
    else $error("buck does not follow wake pin");
  property p_pfm;
    chip_mode == BBM_MODE_STOP && $past(chip_mode) == BBM_MODE_STOP &&
      $stable(cfg) && !cfg.wake_pin_pwm_control && !cfg.auto_pwm_enable
      |-> buck_mod == BBM_MOD_PFM;
  endproperty
  a_pfm: assert property (p_pfm)
    else $error("buck left pfm in stop");
endmodule // bbm_modulation_ctrl_properties
bind bbm_modulation_ctrl bbm_modulation_ctrl_properties u_props (
  .ref_clk, .resetn, .wake_input_pin, .sense, .chip_mode, .buck_mod,
  .buck_enable, .boost_run, .boost_fixed_freq, .buck_fsw_khz, .cfg,
  .auto_pwm_switch_flag, .interrupt_output_n, .reset_output_n,
  .lag_busy, .auto_armed
);

// File: tb/tb_buck_boost_modulation_control.sv
// Testbench for the modulation control
`timescale 1ns/1ps
module tb_buck_boost_modulation_control;
  import bbm_pkg::*;
  localparam int LC = 50;
  localparam int SC = 10;
  logic ref_clk = 0;
  logic resetn = 0;
  logic wake_input_pin = 0;
  logic transceiver_wake = 0;
  logic flag_clear = 0;
  bbm_sense_type sense = '0;
  logic cfg_write, mode_cmd_valid, buck_enable, boost_run, boost_fixed_freq;
  logic auto_pwm_switch_flag, interrupt_output_n, reset_output_n;
  logic lag_busy, auto_armed, buck_soft_start;
  logic [1:0] boost_level;
  logic [15:0] buck_fsw_khz;
  bbm_cfg_type cfg_data, cfg;
  bbm_mode_type mode_cmd, chip_mode;
  bbm_mod_type buck_mod;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  int l;
  // Clock at 50 MHz
  initial forever #10 ref_clk = ~ref_clk;
  bbm_host_model host (.ref_clk, .cfg_write, .cfg_data, .mode_cmd_valid,
    .mode_cmd);
  bbm_modulation_ctrl #(.LONG_CYCLES(16'(LC)), .SHORT_CYCLES(16'(SC))) uut (
    .ref_clk, .resetn, .cfg_write, .cfg_data, .mode_cmd_valid, .mode_cmd,
    .wake_input_pin, .transceiver_wake, .sense, .flag_clear, .chip_mode,
    .buck_mod, .buck_enable, .buck_soft_start, .boost_run, .boost_level,
    .boost_fixed_freq, .buck_fsw_khz, .cfg, .auto_pwm_switch_flag,
    .interrupt_output_n, .reset_output_n, .lag_busy, .auto_armed);
  // Reference buck modulation from mode, config and pin
  function automatic bbm_mod_type ref_mod(bbm_mode_type m, logic trip);
    if (m inside {BBM_MODE_SLEEP, BBM_MODE_FAILSAFE}) return BBM_MOD_OFF;
    if (m != BBM_MODE_STOP) return BBM_MOD_PWM;
    if (cfg_data.auto_pwm_enable) return trip ? BBM_MOD_PWM : BBM_MOD_PFM;
    if (cfg_data.wake_pin_pwm_control && wake_input_pin) return BBM_MOD_PWM;
    return BBM_MOD_PFM;
  endfunction
  task automatic chk(input string s, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // Mode command, then chip mode and buck modulation
  task automatic go(input bbm_mode_type m);
    host.send_mode(m);
    chk("chip_mode", 16'(m), 16'(chip_mode));
    step(1);
    chk("buck_mod", 16'(ref_mod(m, 0)), 16'(buck_mod));
  endtask
  // Bounded wait; running out ends the run
  task automatic bound(input int lim);
    if (n >= lim) begin
      fail_count++;
      finish_test();
    end
  endtask
  // Main sequence
  initial begin
    void'($urandom(51));
    step(3);
    resetn = 1;
    chk("cfg", 16'h0000, 16'(cfg));
    go(BBM_MODE_NORMAL);
    chk("fsw", 16'h01c2, buck_fsw_khz);
    // Default config: no exit from pfm
    wake_input_pin = 1;
    sense.buck_over_pfm_current = 1;
    go(BBM_MODE_STOP);
    step(20);
    chk("buck_mod", 16'(BBM_MOD_PFM), 16'(buck_mod));
    chk("flag", 0, auto_pwm_switch_flag);
    // Auto switch with both lag lengths, pin control also set
    for (int s = 0; s < 2; s++) begin
      sense.buck_over_pfm_current = 0;
      host.set_cfg('{1'b1, 1'b1, s[0], 1'b0, 2'h0});
      go(BBM_MODE_NORMAL);
      go(BBM_MODE_STOP);
      l = s ? LC : SC;
      n = 0;
      while (lag_busy === 1'b1 && n < 200) begin
        step(1);
        n++;
      end
      bound(200);
      chk("lag_len", 1, n >= l - 1 && n <= l + 1);
      step(2);
      chk("armed", 1, auto_armed);
      chk("buck_mod", 16'(BBM_MOD_PFM), 16'(buck_mod));
      sense.buck_over_pfm_current = 1;
      step(1);
      chk("buck_mod", 16'(BBM_MOD_PWM), 16'(buck_mod));
      chk("flag", 1, auto_pwm_switch_flag);
      chk("int_n", 0, interrupt_output_n);
      sense.buck_over_pfm_current = 0;
      wake_input_pin = 0;
      step(5);
      chk("buck_mod", 16'(BBM_MOD_PWM), 16'(buck_mod));
      flag_clear = 1;
      step(1);
      flag_clear = 0;
      step(1);
      chk("flag", 0, auto_pwm_switch_flag);
      go(BBM_MODE_STOP);
      chk("lag_busy", 1, lag_busy);
    end
    // Pin control with random levels, boost enabled
    sense.supply_below_boost_level = 1;
    host.set_cfg('{1'b0, 1'b1, 1'b0, 1'b1, 2'h0});
    go(BBM_MODE_NORMAL);
    go(BBM_MODE_STOP);
    for (int i = 0; i < 8; i++) begin
      wake_input_pin = 1'($urandom);
      step(1);
      chk("pin_mod", 16'(ref_mod(chip_mode, 0)), 16'(buck_mod));
    end
    chk("boost", 1, boost_run);
    chk("level", 2'h0, boost_level);
    // Level change refused while the boost is enabled
    host.set_cfg('{1'b0, 1'b1, 1'b0, 1'b1, 2'h3});
    step(1);
    chk("level_kept", 2'h0, boost_level);
    wake_input_pin = 0;
    go(BBM_MODE_NORMAL);
    chk("boost", 1, boost_run);
    // Sleep and fail-safe, each woken by a different source
    for (int i = 0; i < 2; i++) begin
      go(i ? BBM_MODE_FAILSAFE : BBM_MODE_SLEEP);
      chk("buck_en", 0, buck_enable);
      chk("boost", 0, boost_run);
      sense.buck_above_reset_level = 0;
      if (i) transceiver_wake = 1;
      else wake_input_pin = 1;
      step(2);
      transceiver_wake = 0;
      wake_input_pin = 0;
      chk("mode", 16'(BBM_MODE_RESTART), 16'(chip_mode));
      chk("buck_en", 1, buck_enable);
      chk("boost", 1, boost_run);
      chk("rst_n", 0, reset_output_n);
      chk("soft", 1, buck_soft_start);
      sense.buck_above_reset_level = 1;
      n = 0;
      while (chip_mode !== BBM_MODE_NORMAL && n < 20) begin
        step(1);
        n++;
      end
      bound(20);
      step(1);
      chk("rst_n", 1, reset_output_n);
      chk("soft_end", 0, buck_soft_start);
    end
    finish_test();
  end
endmodule // tb_buck_boost_modulation_control
